// *** aale_top.sv ***
// aale_top: decode and execute of accumulator and pointer register loads
// Behaviour
// - short constant lands in accumulator low byte
// - short load zeroes upper 24 bits always
// - short load opcode is 11001010 in high byte
// - variable load shifts memory word by temp
// - variable shift uses temp bits 3..0 only
// - variable load sign-extends when mode bit set
// - long load shifts second word, pc plus two
// - long load sign-extends or zero-fills above
// - msb set only with sign mode, negative
// - long shift zero to fifteen, default zero
// - pointer load copies memory word to register
// - indirect pointer load has bit7 set
// - same-register indirect load drops the modification
// - pointer load leaves accumulator unchanged
// - left shifts fill low bits with zeros
// - direct address is page pointer and offset
`timescale 1ns/100ps
module aale_top (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// program memory port
	output logic             prog_req_o,
	output logic      [15:0] prog_adr_o,
	input  wire logic [15:0] prog_dat_i,
	input  wire logic        prog_ack_i,
	// data memory port
	output logic             data_req_o,
	output logic      [15:0] data_adr_o,
	input  wire logic [15:0] data_dat_i,
	input  wire logic        data_ack_i
);

	// ----------------------------------------------------------------
	// state and registers
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_DEC   = 3'b010,
		ST_LONG  = 3'b011,
		ST_OPER  = 3'b100
	} aale_state_t;

	aale_state_t                        state;      // sequencer state
	aale_pkg::aale_dec_t                dec;        // latched decoded instruction
	aale_pkg::aale_mreq_t               preq;       // program request
	aale_pkg::aale_mreq_t               dreq;       // data request
	logic [aale_pkg::WORD_W-1:0]        pc;         // program counter
	logic [aale_pkg::WORD_W-1:0]        temp;       // temporary register
	logic [aale_pkg::PAGE_W-1:0]        page_pointer; // direct page
	logic [aale_pkg::SEL_W-1:0]         pointer_select; // current pointer
	logic [aale_pkg::ACC_W-1:0]         acc;        // accumulator
	logic                               run;        // execution enable
	logic                               sign_extension_mode; // extension mode
	logic                               unk_flag;   // sticky unknown opcode
	logic                               unk_set;    // unknown opcode event

	// bus decode
	logic                               bus_req;    // new access this cycle
	logic                               bus_wr;     // write takes effect
	logic [31:0]                        rd_mux;     // read data mux

	// datapath
	logic [aale_pkg::WORD_W-1:0]        sh_in;      // shifter operand
	logic [aale_pkg::SHAMT_W-1:0]       sh_amt;     // shifter count
	logic [aale_pkg::ACC_W-1:0]         sh_res;     // shifter result
	logic [aale_pkg::WORD_W-1:0]        cur_ptr;    // selected pointer value
	logic [aale_pkg::WORD_W-1:0]        bus_ptr;    // pointer read by bus
	logic                               oper_done;  // operand access ends
	logic                               ptr_ld;     // pointer register load
	logic                               ptr_mod;    // pointer modification

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	// one shifter serves both shifted loads
	always_comb begin
		if (state == ST_LONG) begin
			sh_in  = prog_dat_i;
			sh_amt = dec.shift;
		end else begin
			sh_in  = data_dat_i;
			sh_amt = temp[aale_pkg::SHAMT_W-1:0];
		end
	end

	aale_shift #(
		.IN_W  (aale_pkg::WORD_W),
		.OUT_W (aale_pkg::ACC_W),
		.SH_W  (aale_pkg::SHAMT_W)
	) u_shift (
		.opnd_i  (sh_in),
		.shamt_i (sh_amt),
		.sxm_i   (sign_extension_mode),
		.res_o   (sh_res)
	);

	assign oper_done = (state == ST_OPER) && data_ack_i;
	assign ptr_ld    = oper_done && (dec.kind == aale_pkg::K_PTR_LOAD);
	assign ptr_mod   = oper_done && dec.ind &&
	                   (dec.modc == aale_pkg::MOD_DEC || dec.modc == aale_pkg::MOD_INC);

	aale_ptr_file #(
		.W    (aale_pkg::WORD_W),
		.NREG (aale_pkg::NPTR),
		.IW   (aale_pkg::SEL_W)
	) u_ptr (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ld_en_i   (ptr_ld),
		.ld_idx_i  (dec.tgt),
		.ld_val_i  (data_dat_i),
		.mod_en_i  (ptr_mod),
		.mod_idx_i (pointer_select),
		.mod_dec_i (dec.modc == aale_pkg::MOD_DEC),
		.ra_idx_i  (pointer_select),
		.ra_o      (cur_ptr),
		.rb_idx_i  (wb_adr_i[4:2]),
		.rb_o      (bus_ptr)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// fetch, decode, optional second word or operand, then execute
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			dec   <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (run)
						state <= ST_FETCH;
				end
				ST_FETCH: begin
					if (prog_ack_i) begin
						dec   <= aale_pkg::aale_decode(prog_dat_i);
						state <= ST_DEC;
					end
				end
				ST_DEC: begin
					unique case (dec.kind)
						aale_pkg::K_LONG_IMM:  state <= ST_LONG;
						aale_pkg::K_VAR_SHIFT,
						aale_pkg::K_PTR_LOAD:  state <= ST_OPER;
						default:               state <= run ? ST_FETCH : ST_IDLE;
					endcase
				end
				ST_LONG: begin
					if (prog_ack_i)
						state <= run ? ST_FETCH : ST_IDLE;
				end
				ST_OPER: begin
					if (data_ack_i)
						state <= run ? ST_FETCH : ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// program memory request, held until acknowledged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			preq <= '0;
		end else if (preq.req) begin
			if (prog_ack_i)
				preq.req <= 1'b0;
		end else if ((state == ST_IDLE && run) ||
		             (state == ST_DEC && dec.kind == aale_pkg::K_LONG_IMM) ||
		             (state == ST_DEC && dec.kind != aale_pkg::K_VAR_SHIFT &&
		              dec.kind != aale_pkg::K_PTR_LOAD && run) ||
		             (state == ST_OPER && data_ack_i && run) ||
		             (state == ST_FETCH)) begin
			// a fetch state with no request open follows a long load: the
			// constant's ack has just dropped the request, so raise it again
			preq.req <= 1'b1;
			preq.adr <= pc;
		end
	end

	// data memory request with direct or indirect address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dreq <= '0;
		end else if (dreq.req) begin
			if (data_ack_i)
				dreq.req <= 1'b0;
		end else if (state == ST_DEC &&
		             (dec.kind == aale_pkg::K_VAR_SHIFT || dec.kind == aale_pkg::K_PTR_LOAD)) begin
			dreq.req <= 1'b1;
			dreq.adr <= dec.ind ? cur_ptr : {page_pointer, dec.offs};
		end
	end

	// program counter: one per word, bus write otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pc <= aale_pkg::RST_PC;
		else if (prog_ack_i && preq.req)
			pc <= pc + 16'h0001;
		else if (bus_wr && wb_adr_i == aale_pkg::REG_PC)
			pc <= aale_pkg::aale_merge16(pc, wb_dat_i[15:0], wb_sel_i[1:0]);
	end

	// accumulator loads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= aale_pkg::RST_ACC;
		end else if (state == ST_DEC && dec.kind == aale_pkg::K_SHORT_IMM) begin
			acc <= {24'h00_0000, dec.imm};
		end else if (state == ST_LONG && prog_ack_i) begin
			acc <= sh_res;
		end else if (oper_done && dec.kind == aale_pkg::K_VAR_SHIFT) begin
			acc <= sh_res;
		end
		// pointer loads leave acc alone
	end

	// pointer select: next value from indirect forms, else bus
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pointer_select <= aale_pkg::RST_PSEL;
		else if (oper_done && dec.ind && dec.nxt_en)
			pointer_select <= dec.nxt;
		else if (bus_wr && wb_adr_i == aale_pkg::REG_PSEL && wb_sel_i[0])
			pointer_select <= wb_dat_i[aale_pkg::SEL_W-1:0];
	end

	// unknown opcode flag: set wins over a write-one clear
	assign unk_set = (state == ST_DEC) && (dec.kind == aale_pkg::K_NONE);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			unk_flag <= 1'b0;
		else if (unk_set)
			unk_flag <= 1'b1;
		else if (bus_wr && wb_adr_i == aale_pkg::REG_STAT &&
		         wb_sel_i[0] && wb_dat_i[aale_pkg::STAT_UNK])
			unk_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	// software-written configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run                 <= 1'b0;
			sign_extension_mode <= aale_pkg::RST_SXM;
			temp                <= aale_pkg::RST_TEMP;
			page_pointer        <= aale_pkg::RST_PAGE;
		end else if (bus_wr) begin
			unique case (wb_adr_i)
				aale_pkg::REG_CTRL: begin
					if (wb_sel_i[0]) begin
						run                 <= wb_dat_i[aale_pkg::CTRL_RUN];
						sign_extension_mode <= wb_dat_i[aale_pkg::CTRL_SXM];
					end
				end
				aale_pkg::REG_TEMP:
					temp <= aale_pkg::aale_merge16(temp, wb_dat_i[15:0], wb_sel_i[1:0]);
				aale_pkg::REG_PAGE: begin
					if (wb_sel_i[0])
						page_pointer[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						page_pointer[8] <= wb_dat_i[8];
				end
				default: ;
			endcase
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if ((wb_adr_i & aale_pkg::REG_PTR_MASK) == aale_pkg::REG_PTR0)
			rd_mux = {16'h0000, bus_ptr};
		else
			unique case (wb_adr_i)
				aale_pkg::REG_CTRL: rd_mux = {30'h0, sign_extension_mode, run};
				aale_pkg::REG_TEMP: rd_mux = {16'h0000, temp};
				aale_pkg::REG_PAGE: rd_mux = {23'h0, page_pointer};
				aale_pkg::REG_PSEL: rd_mux = {29'h0, pointer_select};
				aale_pkg::REG_PC:   rd_mux = {16'h0000, pc};
				aale_pkg::REG_ACC:  rd_mux = acc;
				aale_pkg::REG_STAT: rd_mux = {30'h0, unk_flag, state != ST_IDLE};
				default:            rd_mux = 32'h0000_0000;
			endcase
	end

	// one-cycle acknowledge with registered read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req)
				wb_dat_o <= rd_mux;
		end
	end

	// memory port outputs straight from request flops
	assign prog_req_o = preq.req;
	assign prog_adr_o = preq.adr;
	assign data_req_o = dreq.req;
	assign data_adr_o = dreq.adr;

endmodule // aale_top

// *** aale_pkg.sv ***
// aale_pkg: constants, types and decode helpers for the load decode and execute block
package aale_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W  = 16;                 // data and instruction word
	localparam int unsigned ACC_W   = 32;                 // accumulator width
	localparam int unsigned PAGE_W  = 9;                  // page pointer width
	localparam int unsigned OFFS_W  = 7;                  // direct offset width
	localparam int unsigned SEL_W   = 3;                  // pointer select width
	localparam int unsigned SHAMT_W = 4;                  // shift count width
	localparam int unsigned NPTR    = 8;                  // number of pointer registers
	localparam int unsigned ADR_W   = 8;                  // wishbone byte address width

	// ----------------------------------------------------------------
	// opcode patterns
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_SHORT_IMM = 8'hca;         // bits 15..8
	localparam logic [8:0] OPC_VAR_SHIFT = 9'h084;        // bits 15..7 direct form
	localparam logic [7:0] OPC_VAR_SHIFT_HI = 8'h42;      // bits 15..8, both forms
	localparam logic [3:0] OPC_LONG_HI   = 4'hd;          // bits 15..12
	localparam logic [7:0] OPC_LONG_LO   = 8'h01;         // bits 7..0
	localparam logic [4:0] OPC_PTR_LOAD  = 5'h06;         // bits 15..11

	// ----------------------------------------------------------------
	// instruction field positions
	// ----------------------------------------------------------------
	localparam int unsigned F_IND_BIT   = 7;              // indirect flag
	localparam int unsigned F_SHIFT_LSB = 8;              // long-immediate shift field
	localparam int unsigned F_SEL_LSB   = 8;              // pointer register select
	localparam int unsigned F_MOD_LSB   = 4;              // indirect modify code, 2 bits
	localparam int unsigned F_NXT_EN    = 3;              // indirect next-select enable
	localparam int unsigned F_NXT_LSB   = 0;              // indirect next select value

	// indirect modify codes
	localparam logic [1:0] MOD_NONE = 2'h0;
	localparam logic [1:0] MOD_DEC  = 2'h1;
	localparam logic [1:0] MOD_INC  = 2'h2;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADR_W-1:0] REG_CTRL   = 8'h00;      // bit0 run, bit1 sign extension mode
	localparam logic [ADR_W-1:0] REG_TEMP   = 8'h04;      // temporary register
	localparam logic [ADR_W-1:0] REG_PAGE   = 8'h08;      // page pointer
	localparam logic [ADR_W-1:0] REG_PSEL   = 8'h0c;      // pointer select
	localparam logic [ADR_W-1:0] REG_PC     = 8'h10;      // program counter
	localparam logic [ADR_W-1:0] REG_ACC    = 8'h14;      // accumulator, read only
	localparam logic [ADR_W-1:0] REG_STAT   = 8'h18;      // bit0 busy, bit1 unknown opcode
	localparam logic [ADR_W-1:0] REG_PTR0   = 8'h20;      // pointer regs 0x20..0x3c, read only
	localparam logic [ADR_W-1:0] REG_PTR_MASK = 8'he0;    // window match mask

	// control and status bit positions
	localparam int unsigned CTRL_RUN  = 0;
	localparam int unsigned CTRL_SXM  = 1;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_UNK  = 1;

	// reset values
	localparam logic [WORD_W-1:0] RST_PC   = 16'h0000;
	localparam logic [WORD_W-1:0] RST_TEMP = 16'h0000;
	localparam logic [PAGE_W-1:0] RST_PAGE = 9'h000;
	localparam logic [SEL_W-1:0]  RST_PSEL = 3'h0;
	localparam logic [ACC_W-1:0]  RST_ACC  = 32'h0000_0000;
	localparam logic              RST_SXM  = 1'b1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		K_NONE      = 3'b000,
		K_SHORT_IMM = 3'b001,
		K_VAR_SHIFT = 3'b010,
		K_LONG_IMM  = 3'b011,
		K_PTR_LOAD  = 3'b100
	} aale_kind_t;

	// decoded instruction fields
	typedef struct packed {
		aale_kind_t           kind;
		logic [7:0]           imm;     // short constant
		logic [SHAMT_W-1:0]   shift;   // long-immediate shift
		logic [SEL_W-1:0]     tgt;     // pointer register target
		logic                 ind;     // indirect form
		logic [OFFS_W-1:0]    offs;    // direct offset
		logic [1:0]           modc;    // indirect modify code
		logic                 nxt_en;  // load new pointer select
		logic [SEL_W-1:0]     nxt;     // new pointer select
	} aale_dec_t;

	// memory request carrier
	typedef struct packed {
		logic              req;
		logic [WORD_W-1:0] adr;
	} aale_mreq_t;

	// ----------------------------------------------------------------
	// decode one instruction word
	// ----------------------------------------------------------------
	function automatic aale_dec_t aale_decode(input logic [WORD_W-1:0] w);
		aale_dec_t d;
		d.kind   = K_NONE;
		d.imm    = w[7:0];
		d.shift  = w[F_SHIFT_LSB +: SHAMT_W];
		d.tgt    = w[F_SEL_LSB +: SEL_W];
		d.ind    = w[F_IND_BIT];
		d.offs   = w[OFFS_W-1:0];
		d.modc   = w[F_MOD_LSB +: 2];
		d.nxt_en = w[F_NXT_EN];
		d.nxt    = w[F_NXT_LSB +: SEL_W];
		if (w[15:8] == OPC_SHORT_IMM)
			d.kind = K_SHORT_IMM;
		else if (w[15:8] == OPC_VAR_SHIFT_HI)
			d.kind = K_VAR_SHIFT;
		else if (w[15:12] == OPC_LONG_HI && w[7:0] == OPC_LONG_LO)
			d.kind = K_LONG_IMM;
		else if (w[15:11] == OPC_PTR_LOAD)
			d.kind = K_PTR_LOAD;
		return d;
	endfunction

	// merge two byte lanes of a write into a 16-bit value
	function automatic logic [15:0] aale_merge16(input logic [15:0] old,
		input logic [15:0] nw, input logic [1:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = nw[7:0];
		if (sel[1])
			r[15:8] = nw[15:8];
		return r;
	endfunction

endpackage

// *** aale_shift.sv ***
// aale_shift: extend a 16-bit operand to accumulator width and shift it left
`timescale 1ns/100ps
module aale_shift #(
	parameter int unsigned IN_W  = 16,
	parameter int unsigned OUT_W = 32,
	parameter int unsigned SH_W  = 4
) (
	// operand and controls
	input  wire logic [IN_W-1:0]  opnd_i,
	input  wire logic [SH_W-1:0]  shamt_i,
	input  wire logic             sxm_i,
	// shifted result
	output logic      [OUT_W-1:0] res_o
);

	logic [OUT_W-1:0] ext;                 // extended operand

	// sign or zero extension, then left shift with zero fill below
	always_comb begin
		ext   = {{(OUT_W-IN_W){sxm_i & opnd_i[IN_W-1]}}, opnd_i};
		res_o = ext << shamt_i;
	end

endmodule // aale_shift

// *** aale_ptr_file.sv ***
// aale_ptr_file: eight pointer registers with load and address modification
`timescale 1ns/100ps
module aale_ptr_file #(
	parameter int unsigned W    = 16,
	parameter int unsigned NREG = 8,
	parameter int unsigned IW   = 3
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// load port
	input  wire logic          ld_en_i,
	input  wire logic [IW-1:0] ld_idx_i,
	input  wire logic [W-1:0]  ld_val_i,
	// modify port
	input  wire logic          mod_en_i,
	input  wire logic [IW-1:0] mod_idx_i,
	input  wire logic          mod_dec_i,
	// read ports
	input  wire logic [IW-1:0] ra_idx_i,
	output logic      [W-1:0]  ra_o,
	input  wire logic [IW-1:0] rb_idx_i,
	output logic      [W-1:0]  rb_o
);

	logic [W-1:0] regs [NREG];             // pointer register array

	// load beats modify on the same register so the loaded value survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NREG; i++) begin
				regs[i] <= '0;
			end
		end else begin
			if (mod_en_i && !(ld_en_i && ld_idx_i == mod_idx_i)) begin
				regs[mod_idx_i] <= mod_dec_i ? regs[mod_idx_i] - W'(1)
				                            : regs[mod_idx_i] + W'(1);
			end
			if (ld_en_i) begin
				regs[ld_idx_i] <= ld_val_i;
			end
		end
	end

	// read ports
	assign ra_o = regs[ra_idx_i];
	assign rb_o = regs[rb_idx_i];

endmodule // aale_ptr_file

// *** aale_mem_model.sv ***
// aale_mem_model: program and data memory answering the core's fetch and operand ports
`timescale 1ns/100ps
module aale_mem_model (
	// clock, reset and pacing
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	// program port
	input  wire logic        prog_req_i,
	input  wire logic [15:0] prog_adr_i,
	output logic      [15:0] prog_dat_o,
	output logic             prog_ack_o,
	// data port
	input  wire logic        data_req_i,
	input  wire logic [15:0] data_adr_i,
	output logic      [15:0] data_dat_o,
	output logic             data_ack_o
);
	logic [15:0] prog [256];	// program words
	logic [15:0] data [256];	// operand words
	logic [1:0]  pw;		// program wait count
	logic [1:0]  dw;		// data wait count
	// program answer: one-cycle ack, word scrambled once its hold has run out
	always_ff @(posedge clk_i) begin
		prog_ack_o <= 1'b0;
		pw <= (prog_req_i && !prog_ack_o) ? pw + 2'h1 : 2'h0;
		if (rst_i)
			prog_dat_o <= 16'h0000;
		else if (prog_req_i && !prog_ack_o && (!slow_i || pw == 2'h3)) begin
			prog_ack_o <= 1'b1;
			prog_dat_o <= prog[prog_adr_i[7:0]];
		end else
			prog_dat_o <= ~prog_dat_o;
	end
	// data answer: same handshake as the program port
	always_ff @(posedge clk_i) begin
		data_ack_o <= 1'b0;
		dw <= (data_req_i && !data_ack_o) ? dw + 2'h1 : 2'h0;
		if (rst_i)
			data_dat_o <= 16'h0000;
		else if (data_req_i && !data_ack_o && (!slow_i || dw == 2'h3)) begin
			data_ack_o <= 1'b1;
			data_dat_o <= data[data_adr_i[7:0]];
		end else
			data_dat_o <= ~data_dat_o;
	end
endmodule // aale_mem_model

// *** aale_top_properties.sv ***
// aale_top_properties: port-level checks of bus and memory handshakes
`timescale 1ns/100ps
module aale_top_properties (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// bus and memory ports
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        prog_req_o,
	input wire logic [15:0] prog_adr_o,
	input wire logic [15:0] prog_dat_i,
	input wire logic        prog_ack_i,
	input wire logic        data_req_o,
	input wire logic [15:0] data_adr_o,
	input wire logic        data_ack_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic cword;	// next program word is a long-load constant
	logic opn;	// fetched word is an operand-reading direct or indirect form
	logic dir;	// fetched word is a direct form
	assign opn = !cword && (prog_dat_i[15:8] == 8'h42 || prog_dat_i[15:11] == 5'h06);
	assign dir = opn && !prog_dat_i[7];
	// track opcode versus constant words
	always_ff @(posedge clk_i)
		if (rst_i)
			cword <= 1'b0;
		else if (prog_ack_i)
			cword <= !cword && prog_dat_i[15:12] == 4'hd && prog_dat_i[7:0] == 8'h01;
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack too long");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus ack without request");
	prog_hold_a: assert property (prog_req_o && !prog_ack_i |=> prog_req_o && $stable(prog_adr_o))
		else $error("fetch request dropped");
	prog_drop_a: assert property (prog_req_o && prog_ack_i |=> !prog_req_o)
		else $error("fetch request held");
	data_hold_a: assert property (data_req_o && !data_ack_i |=> data_req_o && $stable(data_adr_o))
		else $error("operand request dropped");
	data_drop_a: assert property (data_req_o && data_ack_i |=> !data_req_o)
		else $error("operand request held");
	reset_idle_a: assert property (disable iff (1'b0) rst_i |=> !prog_req_o && !data_req_o && !wb_ack_o)
		else $error("ports busy in reset");
	short_nomem_a: assert property (prog_ack_i && !cword && prog_dat_i[15:8] == 8'hca |=> !data_req_o[*3])
		else $error("short load read memory");
	operand_fetch_a: assert property (prog_ack_i && opn |-> ##2 data_req_o)
		else $error("operand not fetched");
	direct_addr_a: assert property (prog_ack_i && dir |-> ##2 data_adr_o[6:0] == $past(prog_dat_i[6:0], 2))
		else $error("direct offset wrong");
endmodule // aale_top_properties
bind aale_top aale_top_properties chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .prog_req_o(prog_req_o), .prog_adr_o(prog_adr_o),
	.prog_dat_i(prog_dat_i), .prog_ack_i(prog_ack_i), .data_req_o(data_req_o),
	.data_adr_o(data_adr_o), .data_ack_i(data_ack_i));

// *** aale_top_tb_top.sv ***
// aale_top_tb_top: single-steps load instructions and checks registers over wishbone
`timescale 1ns/100ps
module aale_top_tb_top;
	logic        clk_i = 1'b0;	// core clock
	logic        rst_i = 1'b1;	// reset
	logic        slow = 1'b0;	// memory pacing
	logic        cyc = 1'b0;	// bus cycle
	logic        we = 1'b0;	// bus direction
	logic [7:0]  adr = 8'h00;	// bus address
	logic [31:0] wdat = 32'h0;	// bus write data
	logic [31:0] rdat;	// last read data
	logic [31:0] dato;	// bus read data
	logic        ack, preq, dreq, pack, dack;	// handshakes
	logic [15:0] padr, dadr, pdat, ddat;	// memory addresses and words
	int          failures = 0;	// mismatches
	int          n_compared = 0;	// comparisons
	int          cycles = 0;	// timeout count
	logic [15:0] pg [12] = '{16'hca85, 16'h4205, 16'hd801, 16'hf794, 16'hd001, 16'h7fff,
		16'hdf01, 16'h0001, 16'h3209, 16'h33ad, 16'h3390, 16'h0000};	// program image
	initial forever #25 clk_i = ~clk_i;
	aale_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
		.prog_req_o(preq), .prog_adr_o(padr), .prog_dat_i(pdat), .prog_ack_i(pack),
		.data_req_o(dreq), .data_adr_o(dadr), .data_dat_i(ddat), .data_ack_i(dack));
	aale_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .prog_req_i(preq),
		.prog_adr_i(padr), .prog_dat_o(pdat), .prog_ack_o(pack), .data_req_i(dreq),
		.data_adr_i(dadr), .data_dat_o(ddat), .data_ack_o(dack));
	// verdict and end of run
	task automatic report_and_stop;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// compare the last read against its expected value
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		n_compared++;
		if (rdat !== e) begin
			failures++;
			$display("Error reg %h expected %h seen %h", a, e, rdat);
		end
	endtask
	// one classic wishbone cycle; read data taken at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dato;
		cyc <= 1'b0;
	endtask
	// run one instruction at pc, wait until idle, then read and compare a register
	task automatic step(input logic [15:0] pc, input logic sx, input logic [7:0] a,
		input logic [31:0] e);
		wb(1'b1, aale_pkg::REG_PC, {16'h0, pc});
		wb(1'b1, aale_pkg::REG_CTRL, {30'h0, sx, 1'b1});
		wb(1'b1, aale_pkg::REG_CTRL, {30'h0, sx, 1'b0});
		rdat = 32'h1;
		while (rdat[0] !== 1'b0)
			wb(1'b0, aale_pkg::REG_STAT, 32'h0);
		wb(1'b0, a, 32'h0);
		chk(a, e);
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	// main sequence
	initial begin
		foreach (pg[i]) mem_u.prog[i] = pg[i];
		mem_u.data[8'h05] = 16'h8001;
		mem_u.data[8'h09] = 16'h0bad;
		mem_u.data[8'h89] = 16'h1234;
		mem_u.data[8'h34] = 16'h00aa;
		mem_u.data[8'haa] = 16'h0042;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, aale_pkg::REG_CTRL, 32'h0);
		chk(aale_pkg::REG_CTRL, 32'h2);
		wb(1'b0, 8'h40, 32'h0);
		chk(8'h40, 32'h0);
		wb(1'b1, aale_pkg::REG_ACC, 32'h55);
		wb(1'b0, aale_pkg::REG_ACC, 32'h0);
		chk(aale_pkg::REG_ACC, 32'h0);
		step(16'h0, 1'b1, aale_pkg::REG_ACC, 32'h0000_0085);
		wb(1'b1, aale_pkg::REG_TEMP, 32'h13);
		step(16'h1, 1'b1, aale_pkg::REG_ACC, 32'hfffc_0008);
		step(16'h1, 1'b0, aale_pkg::REG_ACC, 32'h0004_0008);
		slow <= 1'b1;
		step(16'h2, 1'b1, aale_pkg::REG_ACC, 32'hfff7_9400);
		wb(1'b0, aale_pkg::REG_PC, 32'h0);
		chk(aale_pkg::REG_PC, 32'h4);
		step(16'h2, 1'b0, aale_pkg::REG_ACC, 32'h00f7_9400);
		step(16'h4, 1'b1, aale_pkg::REG_ACC, 32'h0000_7fff);
		step(16'h6, 1'b1, aale_pkg::REG_ACC, 32'h0000_8000);
		slow <= 1'b0;
		wb(1'b1, aale_pkg::REG_PAGE, 32'h1);
		step(16'h8, 1'b1, 8'h28, 32'h1234);
		wb(1'b0, aale_pkg::REG_ACC, 32'h0);
		chk(aale_pkg::REG_ACC, 32'h8000);
		wb(1'b1, aale_pkg::REG_PSEL, 32'h2);
		step(16'h9, 1'b1, 8'h2c, 32'h00aa);
		wb(1'b0, 8'h28, 32'h0);
		chk(8'h28, 32'h1235);
		wb(1'b0, aale_pkg::REG_PSEL, 32'h0);
		chk(aale_pkg::REG_PSEL, 32'h5);
		wb(1'b1, aale_pkg::REG_PSEL, 32'h3);
		step(16'ha, 1'b1, 8'h2c, 32'h0042);
		// unknown opcode sets the sticky flag, a write of one clears it
		step(16'hb, 1'b1, aale_pkg::REG_STAT, 32'h2);
		wb(1'b1, aale_pkg::REG_STAT, 32'h2);
		wb(1'b0, aale_pkg::REG_STAT, 32'h0);
		chk(aale_pkg::REG_STAT, 32'h0);
		wb(1'b0, aale_pkg::REG_PC, 32'h0);
		chk(aale_pkg::REG_PC, 32'hc);
		report_and_stop();
	end
endmodule // aale_top_tb_top
